// *** rtl/ref_trip_pkg.sv ***
package ref_trip_pkg;

  // setting ranges and defaults in percent; desens_factor is a plain multiplier
  localparam logic [9:0] phase_comp_min     = 10'h014;
  localparam logic [9:0] phase_comp_max     = 10'h1f4;
  localparam logic [9:0] phase_comp_def     = 10'h064;
  localparam logic [9:0] neutral_comp_min   = 10'h064;
  localparam logic [9:0] neutral_comp_max   = 10'h3e8;
  localparam logic [9:0] neutral_comp_def   = 10'h1f4;
  localparam logic [7:0] base_sens_min      = 8'h0a;
  localparam logic [7:0] base_sens_max      = 8'h32;
  localparam logic [7:0] base_sens_def      = 8'h1e;
  localparam logic [7:0] slope_min          = 8'h32;
  localparam logic [7:0] slope_max          = 8'h64;
  localparam logic [7:0] slope_def          = 8'h46;
  localparam logic [7:0] breakpoint_min     = 8'h64;
  localparam logic [7:0] breakpoint_max     = 8'hc8;
  localparam logic [7:0] breakpoint_def     = 8'h7d;
  localparam logic [2:0] desens_factor      = 3'h4;
  // reset ratio 0.95 as 95/100
  localparam logic [6:0] reset_ratio_num    = 7'h5f;
  localparam logic [6:0] percent_den        = 7'h64;
  // timing: clock 200 MHz, operate and reset limits
  localparam int         clk_mhz            = 200;
  localparam int         operate_time_ms    = 35;
  localparam int         reset_time_ms      = 25;
  localparam int         operate_cycles     = operate_time_ms * clk_mhz * 1000;
  localparam int         reset_cycles       = reset_time_ms * clk_mhz * 1000;
  localparam int         tick_period_def    = 200000;
  localparam logic [31:0] tick_cnt_reset    = 32'h0000_0000;

  typedef struct packed {
    logic       operation_enable_setting;
    logic       directional_check_enable;
    logic [9:0] phase_side_comp_factor;
    logic [9:0] neutral_side_comp_factor;
    logic [7:0] base_sensitivity_setting;
    logic [7:0] slope_setting;
    logic [7:0] breakpoint_bias_setting;
  } settings_t;

  typedef struct packed {
    logic [15:0] phase_residual;
    logic [15:0] neutral_residual;
  } currents_t;

  typedef struct packed {
    logic [23:0] differential;
    logic [23:0] restraint;
  } measured_t;

endpackage : ref_trip_pkg

// *** rtl/ref_char_eval.sv ***
`timescale 1ns/1ps
module ref_char_eval (
  input  wire ref_trip_pkg::settings_t set_in,
  input  wire ref_trip_pkg::currents_t cur_in,
  input  wire logic                    desensitise_input,
  output logic [23:0]                  diff_out,
  output logic [23:0]                  bias_out,
  output logic [31:0]                  diff_scaled,
  output logic [31:0]                  threshold_scaled
);

  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp10

  function automatic logic [23:0] scale(input logic [15:0] cur, input logic [9:0] fac);
    logic [25:0] prod;
    prod  = 26'(cur) * 26'(fac);
    scale = prod[25:2];
  endfunction : scale

  logic [9:0]  pf;
  logic [9:0]  nf;
  logic [7:0]  f1;
  logic [7:0]  f2;
  logic [7:0]  brk;
  logic [23:0] ip;
  logic [23:0] in_n;
  logic [24:0] sum;
  logic [9:0]  base_eff;
  logic [31:0] flat_thr;
  logic [31:0] slope_thr;

  always_comb begin
    pf   = clamp10(set_in.phase_side_comp_factor, ref_trip_pkg::phase_comp_min,
                   ref_trip_pkg::phase_comp_max); // RULE3
    nf   = clamp10(set_in.neutral_side_comp_factor, ref_trip_pkg::neutral_comp_min,
                   ref_trip_pkg::neutral_comp_max); // RULE3
    f1   = clamp8(set_in.base_sensitivity_setting, ref_trip_pkg::base_sens_min,
                  ref_trip_pkg::base_sens_max); // RULE4
    f2   = clamp8(set_in.slope_setting, ref_trip_pkg::slope_min,
                  ref_trip_pkg::slope_max); // RULE5
    brk  = clamp8(set_in.breakpoint_bias_setting, ref_trip_pkg::breakpoint_min,
                  ref_trip_pkg::breakpoint_max); // RULE1
    ip   = scale(cur_in.phase_residual, pf);
    in_n = scale(cur_in.neutral_residual, nf);
    // differential magnitude of the two signed-free compensated residuals
    diff_out = (ip > in_n) ? (ip - in_n) : (in_n - ip); // RULE11
    sum      = {1'b0, ip} + {1'b0, in_n};
    bias_out = sum[24:1]; // RULE11
    base_eff = desensitise_input ? (10'(f1) * 10'(ref_trip_pkg::desens_factor))
                                 : 10'(f1); // RULE9
    // threshold scaled by 100: flat section, then slope past breakpoint
    flat_thr  = 32'(base_eff) * 32'(ref_trip_pkg::percent_den);
    if (bias_out > 24'(brk)) begin // RULE1
      slope_thr = flat_thr + 32'(bias_out - 24'(brk)) * 32'(f2); // RULE5
    end else begin
      slope_thr = flat_thr;
    end
    threshold_scaled = slope_thr;
    diff_scaled      = 32'(diff_out) * 32'(ref_trip_pkg::percent_den);
  end

endmodule : ref_char_eval

// *** rtl/zero_sequence_differential_trip.sv ***
`timescale 1ns/1ps
// What this block does
// RULE1: one breakpoint, 100 to 200, default 125
// RULE2: trip within 35 ms, release below 0.95
// RULE3: compensation factors 20-500 and 100-1000
// RULE4: base sensitivity 10 to 50, default 30
// RULE5: slope 50 to 100, default 70
// RULE6: operation off forbids any trip
// RULE7: directional check enable, default true
// RULE8: user block input suppresses trip
// RULE9: desensitise multiplies base sensitivity by four
// RULE10: single general trip status output
// RULE11: publish differential and bias currents
// RULE12: no timer stage in trip path
// RULE13: trip above characteristic, unblocked, enabled
// RULE14: blocked by direction or user input
// RULE15: evaluate once per tick, hold between
module zero_sequence_differential_trip #(
  parameter int tick_period = ref_trip_pkg::tick_period_def
) (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire ref_trip_pkg::settings_t settings,
  input  wire ref_trip_pkg::currents_t currents,
  input  wire logic                    direction_blocking,
  input  wire logic                    user_block_input,
  input  wire logic                    desensitise_input,
  output logic                         general_trip_output,
  output logic [23:0]                  differential_current_value,
  output logic [23:0]                  restraint_current_value,
  output logic                         evaluation_tick
);

  typedef enum logic [1:0] {
    st_idle    = 2'b00,
    st_tripped = 2'b01
  } trip_state_t;

  typedef struct packed {
    trip_state_t            state;
    logic                   trip;
    logic [31:0]            tick_cnt;
    logic                   tick;
    ref_trip_pkg::measured_t meas;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [23:0] diff_c;
  logic [23:0] bias_c;
  logic [31:0] diff_s;
  logic [31:0] thr_s;
  logic        blocked;
  logic        above_operate;
  logic        above_reset;
  logic [38:0] thr_reset;

  ref_char_eval u_eval (
    .set_in            (settings),
    .cur_in            (currents),
    .desensitise_input (desensitise_input),
    .diff_out          (diff_c),
    .bias_out          (bias_c),
    .diff_scaled       (diff_s),
    .threshold_scaled  (thr_s)
  );

  always_comb begin
    blocked = user_block_input // RULE8
              | (settings.directional_check_enable & direction_blocking); // RULE7 RULE14
    above_operate = diff_s > thr_s; // RULE13
    // release at 95 percent of the operate threshold
    thr_reset   = 39'(thr_s) * 39'(ref_trip_pkg::reset_ratio_num);
    above_reset = (39'(diff_s) * 39'(ref_trip_pkg::percent_den)) >= thr_reset; // RULE2
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.tick_cnt >= 32'(tick_period - 1)) begin
      state_next.tick_cnt = ref_trip_pkg::tick_cnt_reset;
      state_next.tick     = 1'b1;
    end else begin
      state_next.tick_cnt = state_reg.tick_cnt + 32'h0000_0001;
    end
    if (state_reg.tick) begin // RULE15
      state_next.meas.differential = diff_c; // RULE11
      state_next.meas.restraint    = bias_c; // RULE11
      if (!settings.operation_enable_setting || blocked) begin // RULE6 RULE8 RULE14
        state_next.state = st_idle;
      end else begin
        unique case (state_reg.state)
          st_idle: begin
            if (above_operate) begin // RULE12 RULE13
              state_next.state = st_tripped;
            end
          end
          st_tripped: begin
            if (!above_reset) begin // RULE2
              state_next.state = st_idle;
            end
          end
          default: begin
            state_next.state = st_idle;
          end
        endcase
      end
    end
    state_next.trip = (state_next.state == st_tripped); // RULE10
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    general_trip_output        = state_reg.trip; // RULE10
    differential_current_value = state_reg.meas.differential;
    restraint_current_value    = state_reg.meas.restraint;
    evaluation_tick            = state_reg.tick;
  end

endmodule : zero_sequence_differential_trip

// *** sim/ref_trip_props.sv ***
`timescale 1ns/1ps
module ref_trip_props #(
  parameter int tick_period = 8
) (
  input wire logic                    clk,
  input wire logic                    srst,
  input wire ref_trip_pkg::settings_t settings,
  input wire ref_trip_pkg::currents_t currents,
  input wire logic                    direction_blocking,
  input wire logic                    user_block_input,
  input wire logic                    desensitise_input,
  input wire logic                    general_trip_output,
  input wire logic [23:0]             differential_current_value,
  input wire logic [23:0]             restraint_current_value,
  input wire logic                    evaluation_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  int gap_reg;
  always_ff @(posedge clk) gap_reg <= (srst || evaluation_tick) ? 0 : gap_reg + 1;
  AST_TICK_ONE: assert property (evaluation_tick |=> !evaluation_tick)
    else $error("tick too wide");
  AST_TICK_GAP: assert property (gap_reg <= tick_period)
    else $error("tick missing");
  AST_HOLD_TRIP: assert property (!evaluation_tick |=> $stable(general_trip_output))
    else $error("trip moved between ticks");
  AST_HOLD_VAL: assert property (!evaluation_tick |=>
    $stable(differential_current_value) && $stable(restraint_current_value))
    else $error("values moved between ticks");
  AST_OPER_OFF: assert property (evaluation_tick && !settings.operation_enable_setting
    |=> !general_trip_output) else $error("trip while off");
  AST_USER_BLK: assert property (evaluation_tick && user_block_input
    |=> !general_trip_output) else $error("trip while blocked");
  AST_DIR_BLK: assert property (evaluation_tick && direction_blocking
    && settings.directional_check_enable |=> !general_trip_output)
    else $error("trip in blocking direction");
  AST_NO_CURRENT: assert property (evaluation_tick && currents == '0 |=>
    !general_trip_output && differential_current_value == 24'h0)
    else $error("trip without current");
endmodule : ref_trip_props

// *** sim/ref_trip_partner.sv ***
`timescale 1ns/1ps
module ref_trip_partner (
  input  wire logic clk,
  input  wire logic blk_eq,
  input  wire logic des_eq,
  input  wire logic general_trip_output,
  output logic      user_block_input = 1'b0,
  output logic      desensitise_input = 1'b0,
  output logic      breaker_open = 1'b0
);
  // user equations settle one clock later
  always_ff @(posedge clk) begin
    user_block_input  <= blk_eq;
    desensitise_input <= des_eq;
    breaker_open      <= general_trip_output;
  end
endmodule : ref_trip_partner

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int tp = 8;
  logic clk = 1'b0, srst = 1'b1, direction_blocking = 1'b0, prev = 1'b0;
  logic blk_eq = 1'b0, des_eq = 1'b0, user_block_input, desensitise_input, breaker_open;
  logic general_trip_output, evaluation_tick;
  logic [23:0] differential_current_value, restraint_current_value;
  ref_trip_pkg::settings_t settings = '0;
  ref_trip_pkg::currents_t currents = '0;
  int seed = 32'hf923c4e2;
  int bad_count = 0;
  int check_count = 0;
  logic [48:0] e;
  always #2.5 clk = ~clk;
  ref_trip_partner ref_trip_partner_i (
    .clk                 (clk),
    .blk_eq              (blk_eq),
    .des_eq              (des_eq),
    .general_trip_output (general_trip_output),
    .user_block_input    (user_block_input),
    .desensitise_input   (desensitise_input),
    .breaker_open        (breaker_open)
  );
  zero_sequence_differential_trip #(
    .tick_period (tp)
  ) zero_sequence_differential_trip_i (
    .clk                        (clk),
    .srst                       (srst),
    .settings                   (settings),
    .currents                   (currents),
    .direction_blocking         (direction_blocking),
    .user_block_input           (user_block_input),
    .desensitise_input          (desensitise_input),
    .general_trip_output        (general_trip_output),
    .differential_current_value (differential_current_value),
    .restraint_current_value    (restraint_current_value),
    .evaluation_tick            (evaluation_tick)
  );
  function automatic int rnd(input int lo, input int hi);
    return lo + int'($unsigned($random(seed)) % (hi - lo + 1));
  endfunction : rnd
  function automatic longint lim(input longint v, input longint lo, input longint hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim
  function automatic logic [48:0] model(input logic blocked, input logic des);
    longint a, n, d, b, th, brk;
    a = currents.phase_residual * lim(settings.phase_side_comp_factor,
                                      ref_trip_pkg::phase_comp_min,
                                      ref_trip_pkg::phase_comp_max) / 4;
    n = currents.neutral_residual * lim(settings.neutral_side_comp_factor,
                                        ref_trip_pkg::neutral_comp_min,
                                        ref_trip_pkg::neutral_comp_max) / 4;
    brk = lim(settings.breakpoint_bias_setting, ref_trip_pkg::breakpoint_min,
              ref_trip_pkg::breakpoint_max);
    d = a > n ? a - n : n - a;
    b = (a + n) / 2;
    th = lim(settings.base_sensitivity_setting, ref_trip_pkg::base_sens_min,
             ref_trip_pkg::base_sens_max) * (des ? 400 : 100);
    if (b > brk) begin
      th += (b - brk) * lim(settings.slope_setting, ref_trip_pkg::slope_min,
                            ref_trip_pkg::slope_max);
    end
    return {!blocked && (d * 100 > th || (prev && d * 10000 >= th * 95)), d[23:0], b[23:0]};
  endfunction : model
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 srst = 1'b0;
    for (int i = 0; i < 80; i++) begin
      settings = {1'b1, 1'(rnd(0, 1)), 10'(rnd(20, 500)), 10'(rnd(100, 1000)),
                  8'(rnd(10, 50)), 8'(rnd(50, 100)), 8'(rnd(100, 200))};
      currents = {16'(rnd(0, 400)), 16'(rnd(0, 400))};
      direction_blocking = rnd(0, 3) == 0;
      blk_eq = rnd(0, 5) == 0;
      des_eq = rnd(0, 1) == 1;
      case (i)
        0: currents = '0;
        1: settings.operation_enable_setting = 1'b0;
        2: blk_eq = 1'b1;
        3: {settings.directional_check_enable, direction_blocking} = 2'b11;
        4: {settings.directional_check_enable, direction_blocking} = 2'b01;
        5: settings = {1'b1, 1'b0, 10'h3ff, 10'h000, 8'h00, 8'hff, 8'h00};
        6: settings = {1'b1, 1'b0, 10'h000, 10'h3ff, 8'hff, 8'h00, 8'hff};
        default: ;
      endcase
      for (int k = 0; k < 3 * tp && evaluation_tick !== 1'b1; k++) begin
        @(posedge clk);
        #1;
      end
      chk_bit("tick", 1'b1, evaluation_tick);
      @(posedge clk);
      #1;
      e = model(!settings.operation_enable_setting || blk_eq
                || (settings.directional_check_enable && direction_blocking), des_eq);
      chk_bit("trip", e[48], general_trip_output);
      chk("diff", e[47:24], differential_current_value);
      chk("bias", e[23:0], restraint_current_value);
      prev = e[48];
    end
    tally_and_finish();
  end
endmodule : testbench
bind zero_sequence_differential_trip ref_trip_props #(
  .tick_period (tick_period)
) ref_trip_props_i (
  .clk                        (clk),
  .srst                       (srst),
  .settings                   (settings),
  .currents                   (currents),
  .direction_blocking         (direction_blocking),
  .user_block_input           (user_block_input),
  .desensitise_input          (desensitise_input),
  .general_trip_output        (general_trip_output),
  .differential_current_value (differential_current_value),
  .restraint_current_value    (restraint_current_value),
  .evaluation_tick            (evaluation_tick)
);
